// >>> src/poc_pkg.sv
package poc_pkg;

    // Register offsets on the CPU I/O bus
    localparam logic [5:0] ADDR_CTRL_A   = 6'h30;
    localparam logic [5:0] ADDR_HI_LATCH = 6'h20;
    localparam logic [5:0] ADDR_COUNT    = 6'h21;
    localparam logic [5:0] ADDR_CMP_BASE = 6'h22;

    // Field positions in pwm_output_control_a
    localparam int BIT_OM_A_HI = 7;
    localparam int BIT_OM_A_LO = 6;
    localparam int BIT_OM_B_HI = 5;
    localparam int BIT_OM_B_LO = 4;
    localparam int BIT_FORCE_A = 3;
    localparam int BIT_FORCE_B = 2;
    localparam int BIT_PWM_A   = 1;
    localparam int BIT_PWM_B   = 0;

    localparam logic [7:0] CTRL_A_RESET  = 8'h00;
    // Force bits are strobes and never stored
    localparam logic [7:0] CTRL_A_STORED = 8'hf3;

    // Output-mode codes
    localparam logic [1:0] OM_OFF    = 2'h0;
    localparam logic [1:0] OM_TOGGLE = 2'h1;
    localparam logic [1:0] OM_CLEAR  = 2'h2;
    localparam logic [1:0] OM_SET    = 2'h3;

    localparam logic [9:0] COUNT_BOTTOM = 10'h000;

    typedef enum logic [2:0] {
        MODE_NON_PWM    = 3'h0,
        MODE_FAST       = 3'h1,
        MODE_PHASE      = 3'h2,
        MODE_SIX_SINGLE = 3'h3,
        MODE_SIX_DUAL   = 3'h4
    } poc_mode_e;

endpackage : poc_pkg

// >>> src/poc_top.sv
// Behaviour
// - One two-bit latch shared by all wide registers
// - Low write loads latch+byte; low read fills latch
// - Every wide low-byte read, counter or compare, fills latch
// - Latch survives low-byte writes for reuse
// - Nonzero mode A takes over pin from port
// - Complement pin only in PWM with code 01
// - Pin driver enabled only by direction bit
// - PWM enable and waveform bits select mode
// - Non-PWM: off, toggle, clear, set on match
// - Fast PWM, codes 01/10: clear on match, set at zero; 11 inverts
// - Phase PWM, codes 01/10: clear up-match, set down-match; 11 inverts
// - Six-output: waveform A drives every pin
// - Single-slope six-output like fast; 00 disconnects
// - Dual-slope six-output like phase; 00 disconnects
// - Six-output pin gated by its override enable
`timescale 1ns/100ps
`default_nettype none
module poc_top #(
    parameter int NUM_CMP = 4
) (
    input  wire logic       ref_clk,
    input  wire logic       rst_b,
    input  wire logic [5:0] io_addr,
    input  wire logic [7:0] io_wdata,
    input  wire logic       io_we,
    input  wire logic       io_re,
    output logic      [7:0] io_rdata,
    input  wire logic       waveform_sel_lo,
    input  wire logic       waveform_sel_hi,
    input  wire logic [5:0] pin_override_enables,
    input  wire logic       timer_tick,
    input  wire logic [9:0] timer_count_value,
    input  wire logic       count_down,
    input  wire logic [5:0] port_data,
    input  wire logic [5:0] port_dir,
    output logic            count_load,
    output logic      [9:0] count_load_value,
    output logic      [5:0] compare_out_pins,
    output logic      [5:0] pin_oe,
    output logic      [5:0] pin_function_override
);
    typedef struct packed {
        logic [7:0]               ctrl;
        logic [1:0]               hi_latch;
        logic [NUM_CMP-1:0][9:0]  cmp;
        logic [7:0]               rdata;
        logic                     load;
        logic [9:0]               load_val;
        logic [5:0]               pin_val;
        logic [5:0]               pin_oe;
        logic [5:0]               pin_ovr;
    } poc_top_s;

    poc_top_s           state;
    poc_top_s           next_state;
    logic         [7:0] ctrl_eff;
    logic         [1:0] om_a;
    logic         [1:0] om_b;
    poc_pkg::poc_mode_e mode_a;
    poc_pkg::poc_mode_e mode_b;
    logic               ctrl_wr;
    logic               match_a;
    logic               match_b;
    logic               at_bottom;
    logic               wave_a;
    logic               wave_b;
    logic         [5:0] conn;
    logic         [5:0] val;

    function automatic poc_pkg::poc_mode_e mode_of(input logic pwm_en,
                                                   input logic wsel_hi,
                                                   input logic wsel_lo);
        if (!pwm_en) begin
            mode_of = poc_pkg::MODE_NON_PWM;
        end else if (wsel_hi) begin
            mode_of = wsel_lo ? poc_pkg::MODE_SIX_DUAL
                              : poc_pkg::MODE_SIX_SINGLE;
        end else begin
            mode_of = wsel_lo ? poc_pkg::MODE_PHASE : poc_pkg::MODE_FAST;
        end
    endfunction : mode_of

    function automatic logic is_six(input poc_pkg::poc_mode_e m);
        is_six = (m == poc_pkg::MODE_SIX_SINGLE)
              || (m == poc_pkg::MODE_SIX_DUAL);
    endfunction : is_six

    // Writes to the control register take effect in the same cycle,
    // so a force strobe sees the mode bits written alongside it
    assign ctrl_wr  = io_we && io_addr == poc_pkg::ADDR_CTRL_A;
    assign ctrl_eff = ctrl_wr ? (io_wdata & poc_pkg::CTRL_A_STORED)
                              : state.ctrl;
    assign om_a     = ctrl_eff[poc_pkg::BIT_OM_A_HI:poc_pkg::BIT_OM_A_LO];
    assign om_b     = ctrl_eff[poc_pkg::BIT_OM_B_HI:poc_pkg::BIT_OM_B_LO];
    assign mode_a   = mode_of(ctrl_eff[poc_pkg::BIT_PWM_A],
                              waveform_sel_hi, waveform_sel_lo);
    // Channel B has no six-output form of its own
    assign mode_b   = mode_of(ctrl_eff[poc_pkg::BIT_PWM_B],
                              1'b0, waveform_sel_lo);
    assign match_a   = timer_tick && timer_count_value == state.cmp[0];
    assign match_b   = timer_tick && timer_count_value == state.cmp[1];
    assign at_bottom = timer_tick
                    && timer_count_value == poc_pkg::COUNT_BOTTOM;

    poc_wave u_wave_a (
        .ref_clk     (ref_clk),
        .rst_b       (rst_b),
        .mode        (mode_a),
        .outmode     (om_a),
        .match       (match_a),
        .at_bottom   (at_bottom),
        .count_down  (count_down),
        .force_match (ctrl_wr && io_wdata[poc_pkg::BIT_FORCE_A]),
        .wave        (wave_a)
    );

    poc_wave u_wave_b (
        .ref_clk     (ref_clk),
        .rst_b       (rst_b),
        .mode        (mode_b),
        .outmode     (om_b),
        .match       (match_b),
        .at_bottom   (at_bottom),
        .count_down  (count_down),
        .force_match (ctrl_wr && io_wdata[poc_pkg::BIT_FORCE_B]),
        .wave        (wave_b)
    );

    always_comb begin
        conn = '0;
        val  = '0;
        if (is_six(mode_a)) begin
            for (int i = 0; i < 6; i++) begin
                conn[i] = (om_a != poc_pkg::OM_OFF)
                       && pin_override_enables[i];
                val[i]  = (i % 2 == 1) ? ~wave_a : wave_a;
            end
        end else begin
            conn[0] = (om_a != poc_pkg::OM_OFF);
            val[0]  = wave_a;
            conn[1] = (mode_a != poc_pkg::MODE_NON_PWM)
                   && (om_a == poc_pkg::OM_TOGGLE);
            val[1]  = ~wave_a;
            conn[2] = (om_b != poc_pkg::OM_OFF);
            val[2]  = wave_b;
            conn[3] = (mode_b != poc_pkg::MODE_NON_PWM)
                   && (om_b == poc_pkg::OM_TOGGLE);
            val[3]  = ~wave_b;
        end
    end

    always_comb begin
        next_state         = state;
        next_state.load    = 1'b0;
        next_state.pin_ovr = conn;
        next_state.pin_oe  = port_dir;
        for (int i = 0; i < 6; i++) begin
            next_state.pin_val[i] = conn[i] ? val[i] : port_data[i];
        end
        // Reads first; a write in the same cycle has the last word
        if (io_re) begin
            next_state.rdata = 8'h00;
            if (io_addr == poc_pkg::ADDR_CTRL_A) begin
                next_state.rdata = state.ctrl;
            end else if (io_addr == poc_pkg::ADDR_HI_LATCH) begin
                next_state.rdata = {6'h00, state.hi_latch};
            end else if (io_addr == poc_pkg::ADDR_COUNT) begin
                next_state.rdata    = timer_count_value[7:0];
                next_state.hi_latch = timer_count_value[9:8];
            end
            for (int k = 0; k < NUM_CMP; k++) begin
                if (io_addr == poc_pkg::ADDR_CMP_BASE + 6'(k)) begin
                    next_state.rdata    = state.cmp[k][7:0];
                    next_state.hi_latch = state.cmp[k][9:8];
                end
            end
        end
        // Of the writes only a direct one sets the latch; low writes reuse it
        if (io_we) begin
            if (ctrl_wr) begin
                next_state.ctrl = ctrl_eff;
            end else if (io_addr == poc_pkg::ADDR_HI_LATCH) begin
                next_state.hi_latch = io_wdata[1:0];
            end else if (io_addr == poc_pkg::ADDR_COUNT) begin
                next_state.load     = 1'b1;
                next_state.load_val = {state.hi_latch, io_wdata};
            end
            for (int k = 0; k < NUM_CMP; k++) begin
                if (io_addr == poc_pkg::ADDR_CMP_BASE + 6'(k)) begin
                    next_state.cmp[k] = {state.hi_latch, io_wdata};
                end
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            state      <= '0;
            state.ctrl <= poc_pkg::CTRL_A_RESET;
        end else begin
            state <= next_state;
        end
    end

    assign io_rdata              = state.rdata;
    assign count_load            = state.load;
    assign count_load_value      = state.load_val;
    assign compare_out_pins      = state.pin_val;
    assign pin_oe                = state.pin_oe;
    assign pin_function_override = state.pin_ovr;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    latch_share_a: assert property (io_we && !io_re
        && io_addr == poc_pkg::ADDR_CMP_BASE
        |=> state.cmp[0] == {$past(state.hi_latch), $past(io_wdata)})
        else $error("compare write did not use latch bits");
    count_load_a: assert property (io_we
        && io_addr == poc_pkg::ADDR_COUNT
        |=> count_load && count_load_value[9:8] == $past(state.hi_latch)
        ##1 (count_load == ($past(io_we)
        && $past(io_addr) == poc_pkg::ADDR_COUNT)))
        else $error("counter load pulse wrong");
    low_read_a: assert property (io_re && !io_we
        && io_addr == poc_pkg::ADDR_COUNT
        |=> state.hi_latch == $past(timer_count_value[9:8])
        && io_rdata == $past(timer_count_value[7:0]))
        else $error("low read did not fill latch");
    latch_keep_a: assert property (io_we && !io_re
        && io_addr != poc_pkg::ADDR_HI_LATCH
        |=> $stable(state.hi_latch))
        else $error("latch changed on a low write");
    pin_take_a: assert property (om_a != poc_pkg::OM_OFF
        && !is_six(mode_a) |=> pin_function_override[0])
        else $error("mode A did not take the pin");
    comp_pin_a: assert property ((om_a != poc_pkg::OM_TOGGLE
        || mode_a == poc_pkg::MODE_NON_PWM) && !is_six(mode_a)
        |=> !pin_function_override[1])
        else $error("complement pin connected wrongly");
    oe_dir_a: assert property (1'b1 |=> pin_oe == $past(port_dir))
        else $error("driver enable not from direction");
    mode_sel_a: assert property (!ctrl_eff[poc_pkg::BIT_PWM_A]
        |-> mode_a == poc_pkg::MODE_NON_PWM)
        else $error("mode chosen without PWM enable");
    six_route_a: assert property (is_six(mode_a) && om_a != 2'h0
        && pin_override_enables[3] |=> pin_function_override[3]
        && compare_out_pins[3] == !$past(wave_a))
        else $error("six-output pin not routed");
    six_off_a: assert property (is_six(mode_a)
        && om_a == poc_pkg::OM_OFF |=> pin_function_override == 6'h00)
        else $error("six-output code 00 left a pin connected");
    six_gate_a: assert property (is_six(mode_a)
        && !pin_override_enables[2]
        |=> compare_out_pins[2] == $past(port_data[2]))
        else $error("disabled override did not show port");
    reset_ctrl_a: assert property ($rose(rst_b)
        |-> state.ctrl == poc_pkg::CTRL_A_RESET)
        else $error("control not zero after reset");
    force_zero_a: assert property (io_re && !io_we
        && io_addr == poc_pkg::ADDR_CTRL_A |=> io_rdata[3:2] == 2'h0)
        else $error("force bits read back");

    six_pwm_c: cover property (is_six(mode_a) && pin_override_enables[0]
        && om_a != poc_pkg::OM_OFF ##1 pin_function_override[0]);
    fast_match_c: cover property (mode_a == poc_pkg::MODE_FAST && match_a);
    shared_write_c: cover property (io_we && io_addr == poc_pkg::ADDR_HI_LATCH
        ##1 io_we && io_addr == poc_pkg::ADDR_CMP_BASE);
    count_read_c: cover property (io_re && io_addr == poc_pkg::ADDR_COUNT
        ##1 io_re && io_addr == poc_pkg::ADDR_HI_LATCH);
endmodule : poc_top
`default_nettype wire

// >>> src/poc_wave.sv
`timescale 1ns/100ps
`default_nettype none
module poc_wave (
    input  wire logic              ref_clk,
    input  wire logic              rst_b,
    input  wire poc_pkg::poc_mode_e mode,
    input  wire logic [1:0]        outmode,
    input  wire logic              match,
    input  wire logic              at_bottom,
    input  wire logic              count_down,
    input  wire logic              force_match,
    output logic                   wave
);
    typedef struct packed {
        logic wave;
    } poc_wave_s;

    poc_wave_s state;
    poc_wave_s next_state;

    assign wave = state.wave;

    always_comb begin
        next_state = state;
        case (mode)
            poc_pkg::MODE_NON_PWM: begin
                // Force acts as a match, only here
                if (match || force_match) begin
                    case (outmode)
                        poc_pkg::OM_TOGGLE: next_state.wave = ~state.wave;
                        poc_pkg::OM_CLEAR:  next_state.wave = 1'b0;
                        poc_pkg::OM_SET:    next_state.wave = 1'b1;
                        default:            next_state.wave = state.wave;
                    endcase
                end
            end
            poc_pkg::MODE_FAST, poc_pkg::MODE_SIX_SINGLE: begin
                // Match wins when compare value is zero
                if (outmode != poc_pkg::OM_OFF) begin
                    if (match) begin
                        next_state.wave = (outmode == poc_pkg::OM_SET);
                    end else if (at_bottom) begin
                        next_state.wave = (outmode != poc_pkg::OM_SET);
                    end
                end
            end
            poc_pkg::MODE_PHASE, poc_pkg::MODE_SIX_DUAL: begin
                if (outmode != poc_pkg::OM_OFF && match) begin
                    next_state.wave = count_down ?
                        (outmode != poc_pkg::OM_SET) :
                        (outmode == poc_pkg::OM_SET);
                end
            end
            default: next_state = state;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    toggle_match_a: assert property (mode == poc_pkg::MODE_NON_PWM
        && outmode == poc_pkg::OM_TOGGLE && (match || force_match)
        |=> wave != $past(wave))
        else $error("toggle on match did not toggle");
    fast_clear_a: assert property ((mode == poc_pkg::MODE_FAST
        || mode == poc_pkg::MODE_SIX_SINGLE) && match
        && (outmode == poc_pkg::OM_TOGGLE || outmode == poc_pkg::OM_CLEAR)
        |=> !wave)
        else $error("single-slope match did not clear");
    bottom_set_a: assert property (mode == poc_pkg::MODE_SIX_SINGLE
        && outmode == poc_pkg::OM_SET && at_bottom && !match |=> !wave)
        else $error("inverted single-slope bottom did not clear");
    dual_slope_a: assert property ((mode == poc_pkg::MODE_PHASE
        || mode == poc_pkg::MODE_SIX_DUAL) && match
        && outmode == poc_pkg::OM_SET |=> wave == !$past(count_down))
        else $error("dual-slope inverted match wrong");
    dual_down_a: assert property (mode == poc_pkg::MODE_SIX_DUAL
        && match && count_down && outmode == poc_pkg::OM_CLEAR |=> wave)
        else $error("dual-slope down-count match did not set");
endmodule : poc_wave
`default_nettype wire

// >>> tb/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic       ref_clk              = 1'b0;
    logic       rst_b                = 1'b0;
    logic [5:0] io_addr              = 6'h00;
    logic [7:0] io_wdata             = 8'h00;
    logic       io_we                = 1'b0;
    logic       io_re                = 1'b0;
    logic [7:0] io_rdata;
    logic       waveform_sel_lo      = 1'b0;
    logic       waveform_sel_hi      = 1'b0;
    logic [5:0] pin_override_enables = 6'h00;
    logic       timer_tick           = 1'b0;
    logic [9:0] timer_count_value    = 10'h000;
    logic       count_down           = 1'b0;
    logic [5:0] port_data            = 6'h00;
    logic [5:0] port_dir             = 6'h3f;
    logic       count_load;
    logic [9:0] count_load_value;
    logic [5:0] compare_out_pins;
    logic [5:0] pin_oe;
    logic [5:0] pin_function_override;
    int         fails                = 0;
    int         compares             = 0;

    poc_top #(.NUM_CMP(4)) DUT (
        .ref_clk              (ref_clk),
        .rst_b                (rst_b),
        .io_addr              (io_addr),
        .io_wdata             (io_wdata),
        .io_we                (io_we),
        .io_re                (io_re),
        .io_rdata             (io_rdata),
        .waveform_sel_lo      (waveform_sel_lo),
        .waveform_sel_hi      (waveform_sel_hi),
        .pin_override_enables (pin_override_enables),
        .timer_tick           (timer_tick),
        .timer_count_value    (timer_count_value),
        .count_down           (count_down),
        .port_data            (port_data),
        .port_dir             (port_dir),
        .count_load           (count_load),
        .count_load_value     (count_load_value),
        .compare_out_pins     (compare_out_pins),
        .pin_oe               (pin_oe),
        .pin_function_override(pin_function_override)
    );

    always #12.5 ref_clk = ~ref_clk;

    task automatic chk(input logic [9:0] got, input logic [9:0] exp,
                       input string msg);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t %s got %h exp %h", $time, msg,
                     got, exp);
        end
    endtask : chk

    // Strobes rise and fall on falling edges, one rising edge takes them
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        io_addr  = a;
        io_wdata = d;
        io_we    = 1'b1;
        @(negedge ref_clk);
        io_we    = 1'b0;
    endtask : wr

    task automatic rd(input logic [5:0] a, input logic [7:0] exp);
        @(negedge ref_clk);
        io_addr = a;
        io_re   = 1'b1;
        @(negedge ref_clk);
        io_re   = 1'b0;
        chk({2'h0, io_rdata}, {2'h0, exp}, "read data");
    endtask : rd

    // Waveform flop moves one edge after the match, pins one edge later
    task automatic tick(input logic [9:0] cnt, input logic dn);
        timer_count_value = cnt;
        count_down        = dn;
        timer_tick        = 1'b1;
        @(negedge ref_clk);
        timer_tick        = 1'b0;
        @(negedge ref_clk);
    endtask : tick

    task automatic t_regs;
        rd(poc_pkg::ADDR_CTRL_A, poc_pkg::CTRL_A_RESET);
        rd(6'h3f, 8'h00);
        wr(poc_pkg::ADDR_CTRL_A, 8'hff);
        rd(poc_pkg::ADDR_CTRL_A, 8'hf3);
        wr(poc_pkg::ADDR_CTRL_A, 8'h00);
    endtask : t_regs

    task automatic t_latch;
        // Latch first, nothing may slip in between the two bytes
        wr(poc_pkg::ADDR_HI_LATCH, 8'h01);
        wr(poc_pkg::ADDR_COUNT, 8'h34);
        chk({9'h0, count_load}, 10'h001, "load pulse");
        chk(count_load_value, 10'h134, "load value");
        @(negedge ref_clk);
        chk({9'h0, count_load}, 10'h000, "load pulse end");
        // Compare 0 reuses the latch left by the counter write
        wr(poc_pkg::ADDR_CMP_BASE, 8'h00);
        wr(poc_pkg::ADDR_HI_LATCH, 8'h03);
        rd(poc_pkg::ADDR_CMP_BASE, 8'h00);
        rd(poc_pkg::ADDR_HI_LATCH, 8'h01);
        timer_count_value = 10'h2c7;
        rd(poc_pkg::ADDR_COUNT, 8'hc7);
        rd(poc_pkg::ADDR_HI_LATCH, 8'h02);
    endtask : t_latch

    task automatic t_nonpwm;
        port_data = 6'h02;
        port_dir  = 6'h05;
        wr(poc_pkg::ADDR_CTRL_A, 8'hc8);
        chk({4'h0, pin_function_override}, 10'h001, "override");
        chk({4'h0, pin_oe}, 10'h005, "pin enable");
        @(negedge ref_clk);
        chk({4'h0, compare_out_pins}, 10'h003, "force set");
        wr(poc_pkg::ADDR_CTRL_A, 8'h88);
        @(negedge ref_clk);
        chk({9'h0, compare_out_pins[0]}, 10'h000, "force clear");
        wr(poc_pkg::ADDR_CTRL_A, 8'h48);
        @(negedge ref_clk);
        chk({9'h0, compare_out_pins[0]}, 10'h001, "toggle");
        wr(poc_pkg::ADDR_CTRL_A, 8'h48);
        @(negedge ref_clk);
        chk({9'h0, compare_out_pins[0]}, 10'h000, "toggle back");
        port_dir  = 6'h3f;
        port_data = 6'h00;
        wr(poc_pkg::ADDR_CTRL_A, 8'h00);
        chk({4'h0, pin_function_override}, 10'h000, "released");
        chk({4'h0, pin_oe}, 10'h03f, "pin enable");
    endtask : t_nonpwm

    task automatic t_fast;
        wr(poc_pkg::ADDR_CTRL_A, 8'h42);
        chk({4'h0, pin_function_override}, 10'h003, "fast 01");
        tick(10'h000, 1'b0);
        chk({8'h0, compare_out_pins[1:0]}, 10'h001, "set at bottom");
        tick(10'h100, 1'b0);
        chk({8'h0, compare_out_pins[1:0]}, 10'h002, "clear match");
        wr(poc_pkg::ADDR_CTRL_A, 8'hc2);
        chk({4'h0, pin_function_override}, 10'h001, "fast 11");
        tick(10'h100, 1'b0);
        chk({9'h0, compare_out_pins[0]}, 10'h001, "set on match");
        tick(10'h000, 1'b0);
        chk({9'h0, compare_out_pins[0]}, 10'h000, "clear bottom");
        // Channel B in fast PWM with code 01 owns both of its pins
        wr(poc_pkg::ADDR_CTRL_A, 8'h13);
        chk({4'h0, pin_function_override}, 10'h00c, "fast B 01");
    endtask : t_fast

    task automatic t_phase;
        waveform_sel_lo = 1'b1;
        wr(poc_pkg::ADDR_CTRL_A, 8'h82);
        chk({4'h0, pin_function_override}, 10'h001, "phase 10");
        tick(10'h100, 1'b1);
        chk({9'h0, compare_out_pins[0]}, 10'h001, "down match");
        tick(10'h100, 1'b0);
        chk({9'h0, compare_out_pins[0]}, 10'h000, "up match");
        wr(poc_pkg::ADDR_CTRL_A, 8'hc2);
        tick(10'h100, 1'b0);
        chk({9'h0, compare_out_pins[0]}, 10'h001, "up set");
    endtask : t_phase

    task automatic t_six;
        // Port bits are set opposite to the wave so gating errors show
        waveform_sel_hi      = 1'b1;
        waveform_sel_lo      = 1'b0;
        pin_override_enables = 6'h2a;
        port_data            = 6'h15;
        wr(poc_pkg::ADDR_CTRL_A, 8'he2);
        tick(10'h000, 1'b0);
        chk({4'h0, compare_out_pins}, 10'h03f, "six single");
        pin_override_enables = 6'h15;
        port_data            = 6'h00;
        @(negedge ref_clk);
        @(negedge ref_clk);
        chk({4'h0, compare_out_pins}, 10'h000, "six gated");
        // Dual slope: down match sets, up match clears, all pins follow
        pin_override_enables = 6'h3f;
        waveform_sel_lo      = 1'b1;
        wr(poc_pkg::ADDR_CTRL_A, 8'ha2);
        tick(10'h100, 1'b1);
        chk({4'h0, compare_out_pins}, 10'h015, "six dual down");
        tick(10'h100, 1'b0);
        chk({4'h0, compare_out_pins}, 10'h02a, "six dual");
        wr(poc_pkg::ADDR_CTRL_A, 8'h22);
        chk({4'h0, pin_function_override}, 10'h000, "six off");
        waveform_sel_hi      = 1'b0;
        waveform_sel_lo      = 1'b0;
    endtask : t_six

    task automatic tally_and_finish;
        $display("compares=%0d fails=%0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        repeat (5) @(negedge ref_clk);
        chk({4'h0, pin_oe}, 10'h000, "reset pins");
        rst_b = 1'b1;
        t_regs();
        t_latch();
        t_nonpwm();
        t_fast();
        t_phase();
        t_six();
        tally_and_finish();
    end

    // The sequence needs under a hundred cycles; 5000 allow ample margin
    initial begin
        #(25 * 5000);
        fails++;
        tally_and_finish();
    end
endmodule : tb
`default_nettype wire
